// ===== vps_pkg.sv
// Purpose: Shared constants and types for the line-16 label decoder
// Assumes: 200 MHz system clock
// Notes: Sync timing counts are derived from times in ns, the tick count from rates in Hz
package vps_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int unsigned TICK_HZ = 5_000_000;
   localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int unsigned TICK_HALF = TICK_CYC / 2;
   localparam int unsigned BROAD_NS = 15000;
   localparam int unsigned BROAD_CYC = (BROAD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LINE_GAP_NS = 48000;
   localparam int unsigned LINE_GAP_CYC_DEF = (LINE_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W = 15;
   localparam int TICK_W = 6;
   localparam logic [4:0] LINE_VPS = 5'h10;
   localparam logic [4:0] LINE_AT_VSYNC = 5'h01;
   localparam logic [4:0] LINE_SAT = 5'h1F;
   localparam logic [3:0] BYTE_FIRST = 4'h3;
   localparam logic [3:0] BYTE_LAST = 4'hE;
   localparam logic [3:0] BYTE_SINGLE = 4'h5;
   localparam logic [3:0] BYTE_RUN = 4'hB;
   localparam int START_W = 14;
   localparam logic [13:0] START_PAT_DEF = 14'h3A65;
   localparam logic FIRST_PARITY = 1'b1;
   localparam logic [7:0] ADDR_BASE = 8'h21;
   localparam int ADDR_SEL_BIT = 1;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam int NSLOT = 5;
   localparam logic [2:0] SLOT_LAST = 3'h4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_SEND, I2C_ACKM} i2c_state_t;
   typedef enum logic [1:0] {DEC_IDLE, DEC_HUNT, DEC_DATA, DEC_DONE} dec_state_t;
endpackage : vps_pkg

// ===== vps_i2c_if.sv
// Purpose: Carrier between decoder core and serial slave
// Assumes: Pins already synchronised
// Notes: Slave reports busy and end of a read
`timescale 1ns/1ps
`default_nettype none
interface vps_i2c_if;
   logic scl;
   logic sda;
   logic addr_sel;
   logic [7:0] tx_byte;
   logic busy;
   logic read_done;
   logic sda_oe;
   logic [2:0] slot;
   modport slave (input scl, sda, addr_sel, tx_byte, output busy, read_done, sda_oe, slot);
   modport core (output scl, sda, addr_sel, tx_byte, input busy, read_done, sda_oe, slot);
endinterface : vps_i2c_if
`default_nettype wire

// ===== vps_i2c_slave.sv
// Purpose: Read-only serial slave transmitter
// Assumes: scl and sda are synchronised to i_mclk
// Notes: Drives sda low only; oe high pulls the line low
`timescale 1ns/1ps
`default_nettype none
module vps_i2c_slave (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   vps_i2c_if.slave bus
);
   vps_pkg::i2c_state_t state_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic [3:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [2:0] slot_reg;
   logic oe_reg;
   logic sent_reg;
   logic done_reg;
   wire scl_rise = bus.scl & ~scl_d_reg;
   wire scl_fall = ~bus.scl & scl_d_reg;
   wire start_cond = bus.scl & scl_d_reg & sda_d_reg & ~bus.sda;
   wire stop_cond = bus.scl & scl_d_reg & ~sda_d_reg & bus.sda;
   wire [7:0] my_addr = {vps_pkg::ADDR_BASE[7:2], bus.addr_sel, vps_pkg::ADDR_BASE[0]};
   wire [2:0] slot_next = (slot_reg == vps_pkg::SLOT_LAST) ? 3'h0 : slot_reg + 3'h1;

   assign bus.busy = (state_reg != vps_pkg::I2C_IDLE);
   assign bus.read_done = done_reg;
   assign bus.sda_oe = oe_reg;
   assign bus.slot = slot_reg;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= vps_pkg::I2C_IDLE;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         slot_reg <= 3'h0;
         oe_reg <= 1'b0;
         sent_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         scl_d_reg <= bus.scl;
         sda_d_reg <= bus.sda;
         done_reg <= 1'b0;
         if (start_cond) begin
            state_reg <= vps_pkg::I2C_ADDR;
            cnt_reg <= 4'h0;
            slot_reg <= 3'h0;
            oe_reg <= 1'b0;
            done_reg <= sent_reg;
            sent_reg <= 1'b0;
         end else if (stop_cond) begin
            state_reg <= vps_pkg::I2C_IDLE;
            oe_reg <= 1'b0;
            done_reg <= sent_reg;
            sent_reg <= 1'b0;
         end else begin
            unique case (state_reg)
               vps_pkg::I2C_IDLE: begin
                  oe_reg <= 1'b0;
               end
               vps_pkg::I2C_ADDR: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], bus.sda};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == vps_pkg::BITS_PER_BYTE) begin
                     // Write direction is never acknowledged
                     if (shift_reg == my_addr) begin
                        oe_reg <= 1'b1;
                        state_reg <= vps_pkg::I2C_ACKA;
                     end else begin
                        state_reg <= vps_pkg::I2C_IDLE;
                     end
                  end
               end
               vps_pkg::I2C_ACKA: begin
                  if (scl_fall) begin
                     shift_reg <= bus.tx_byte;
                     oe_reg <= ~bus.tx_byte[7];
                     cnt_reg <= 4'h0;
                     state_reg <= vps_pkg::I2C_SEND;
                  end
               end
               vps_pkg::I2C_SEND: begin
                  if (scl_rise) begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_reg == vps_pkg::BITS_PER_BYTE) begin
                        oe_reg <= 1'b0;
                        state_reg <= vps_pkg::I2C_ACKM;
                     end else begin
                        oe_reg <= ~shift_reg[6];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                     end
                  end
               end
               vps_pkg::I2C_ACKM: begin
                  if (scl_rise) begin
                     sent_reg <= 1'b1;
                     if (!bus.sda) begin
                        slot_reg <= slot_next;
                        state_reg <= vps_pkg::I2C_ACKA;
                     end else begin
                        state_reg <= vps_pkg::I2C_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule : vps_i2c_slave
`default_nettype wire

// ===== vps_line16_decoder.sv
// Purpose: Line-16 label telegram decoder with serial read-out
// Assumes: Sliced data and composite sync arrive as logic levels
// Notes: Sync is active low; all pins are synchronised first
// Contract
// - 5 MHz time base locked to lines
// - Find line 16, decode only there
// - Check start code and biphase, store result
// - Answer address 21h or 23h by select
// - First-field output high in first field
// - Line-present output shows telegram reception in the first field
// - Test select swaps outputs for internal signals
// - Start condition points to byte 11
// - After a read, registers become FF
// - Update only on good telegram, bus idle
`timescale 1ns/1ps
`default_nettype none
module vps_line16_decoder #(
   parameter int unsigned LINE_GAP_CYC = vps_pkg::LINE_GAP_CYC_DEF,
   parameter logic [vps_pkg::START_W-1:0] START_PAT = vps_pkg::START_PAT_DEF
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_composite_sync_b,
   input wire logic i_sliced_data,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_address_select,
   input wire logic i_test_select,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_vps_line_present,
   output logic o_first_field
);
   localparam int NSYNC = 6;
   // Pin idle levels, so no false edge follows reset
   localparam logic [NSYNC-1:0] PIN_IDLE = 6'h0D;
   logic [NSYNC-1:0] meta_reg;
   logic [NSYNC-1:0] pin_reg;
   wire sync_b = pin_reg[0];
   wire data_in = pin_reg[1];
   wire test_sel = pin_reg[5];
   wire addr_sel = pin_reg[4];

   vps_i2c_if bus ();
   assign bus.scl = pin_reg[2];
   assign bus.sda = pin_reg[3];
   assign bus.addr_sel = addr_sel;

   logic sync_d_reg;
   logic data_d_reg;
   logic [vps_pkg::TMR_W-1:0] low_reg;
   logic [vps_pkg::TMR_W-1:0] gap_reg;
   logic [4:0] line_reg;
   logic [3:0] eq_reg;
   logic vs_seen_reg;
   logic field1_reg;
   logic [vps_pkg::TICK_W-1:0] tick_cnt_reg;
   logic tick_tgl_reg;
   logic line16_d_reg;
   vps_pkg::dec_state_t dec_reg;
   logic [vps_pkg::START_W-1:0] pat_reg;
   logic half_reg;
   logic h1_reg;
   logic [6:0] sh_reg;
   logic [2:0] bit_reg;
   logic [3:0] byte_reg;
   logic err_reg;
   logic got_ok_reg;
   logic present_reg;
   logic [7:0] buf_reg [vps_pkg::NSLOT];
   logic [7:0] tx_reg [vps_pkg::NSLOT];
   logic lp_reg;
   logic ff_reg;
   logic sda_out_reg;

   function automatic logic slot_valid(input logic [3:0] idx);
      slot_valid = (idx == vps_pkg::BYTE_SINGLE) ||
                   (idx >= vps_pkg::BYTE_RUN && idx <= vps_pkg::BYTE_LAST);
   endfunction : slot_valid

   function automatic logic [2:0] slot_of(input logic [3:0] idx);
      logic [3:0] d;
      d = idx - vps_pkg::BYTE_RUN;
      slot_of = (idx == vps_pkg::BYTE_SINGLE) ? vps_pkg::SLOT_LAST : d[2:0];
   endfunction : slot_of

   // Sync pulse timing and line counting
   wire sync_fall = ~sync_b & sync_d_reg;
   wire broad = ~sync_b && (low_reg == vps_pkg::BROAD_CYC[vps_pkg::TMR_W-1:0]);
   wire full_line = (gap_reg >= LINE_GAP_CYC[vps_pkg::TMR_W-1:0]);
   wire line16 = (line_reg == vps_pkg::LINE_VPS);
   wire tmr_sat = &gap_reg;

   // Half-bit time base
   wire data_edge = data_in ^ data_d_reg;
   wire tick = (tick_cnt_reg == vps_pkg::TICK_CYC[vps_pkg::TICK_W-1:0] - 6'h01);

   // Telegram bit assembly
   wire [vps_pkg::START_W-1:0] pat_next = {pat_reg[vps_pkg::START_W-2:0], data_in};
   wire bit_bad = (data_in == h1_reg);
   wire [7:0] byte_val = {sh_reg, h1_reg};
   wire byte_end = (dec_reg == vps_pkg::DEC_DATA) && tick && half_reg && (bit_reg == 3'h7);
   wire last_byte = byte_end && (byte_reg == vps_pkg::BYTE_LAST);
   wire telegram_ok = last_byte && ~err_reg && ~bit_bad;
   wire commit = telegram_ok && ~bus.busy;
   wire [2:0] cur_slot = slot_of(byte_reg);

   assign bus.tx_byte = tx_reg[bus.slot];

   // Output selection, test signals by address select
   wire lp_next = test_sel ? (addr_sel ? sync_b : line16) : present_reg;
   wire ff_next = test_sel ? (addr_sel ? err_reg : tick_tgl_reg) : field1_reg;

   vps_i2c_slave i_vps_i2c_slave (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .bus(bus)
   );

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= PIN_IDLE;
         pin_reg <= PIN_IDLE;
      end else begin
         meta_reg <= {i_test_select, i_address_select, i_sda, i_scl, i_sliced_data,
                      i_composite_sync_b};
         pin_reg <= meta_reg;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_d_reg <= 1'b1;
         low_reg <= '0;
         gap_reg <= '0;
         line_reg <= vps_pkg::LINE_SAT;
         eq_reg <= 4'h0;
         vs_seen_reg <= 1'b0;
         field1_reg <= 1'b0;
      end else begin
         sync_d_reg <= sync_b;
         low_reg <= sync_b ? '0 : (low_reg + {{(vps_pkg::TMR_W-1){1'b0}}, ~(&low_reg)});
         if (sync_fall) begin
            gap_reg <= '0;
            if (full_line) begin
               eq_reg <= 4'h0;
               vs_seen_reg <= 1'b0;
               if (line_reg != vps_pkg::LINE_SAT) begin
                  line_reg <= line_reg + 5'h01;
               end
            end else begin
               eq_reg <= eq_reg + 4'h1;
            end
         end else begin
            gap_reg <= gap_reg + {{(vps_pkg::TMR_W-1){1'b0}}, ~tmr_sat};
         end
         if (broad && !vs_seen_reg) begin
            vs_seen_reg <= 1'b1;
            line_reg <= vps_pkg::LINE_AT_VSYNC;
            field1_reg <= (eq_reg[0] == vps_pkg::FIRST_PARITY);
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         data_d_reg <= 1'b0;
         tick_cnt_reg <= '0;
         tick_tgl_reg <= 1'b0;
      end else begin
         data_d_reg <= data_in;
         if (sync_fall) begin
            tick_cnt_reg <= '0;
         end else if (line16 && data_edge) begin
            tick_cnt_reg <= vps_pkg::TICK_HALF[vps_pkg::TICK_W-1:0];
         end else if (tick) begin
            tick_cnt_reg <= '0;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 6'h01;
         end
         if (tick) begin
            tick_tgl_reg <= ~tick_tgl_reg;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dec_reg <= vps_pkg::DEC_IDLE;
         pat_reg <= '0;
         half_reg <= 1'b0;
         h1_reg <= 1'b0;
         sh_reg <= 7'h00;
         bit_reg <= 3'h0;
         byte_reg <= vps_pkg::BYTE_FIRST;
         err_reg <= 1'b0;
         got_ok_reg <= 1'b0;
         present_reg <= 1'b0;
         line16_d_reg <= 1'b0;
      end else begin
         line16_d_reg <= line16;
         if (line16_d_reg && !line16 && field1_reg) begin
            present_reg <= got_ok_reg;
         end
         if (!line16) begin
            dec_reg <= vps_pkg::DEC_IDLE;
         end else if (tick) begin
            unique case (dec_reg)
               vps_pkg::DEC_IDLE: begin
                  dec_reg <= vps_pkg::DEC_HUNT;
                  pat_reg <= '0;
                  err_reg <= 1'b0;
                  got_ok_reg <= 1'b0;
               end
               vps_pkg::DEC_HUNT: begin
                  pat_reg <= pat_next;
                  if (pat_next == START_PAT) begin
                     dec_reg <= vps_pkg::DEC_DATA;
                     byte_reg <= vps_pkg::BYTE_FIRST;
                     bit_reg <= 3'h0;
                     half_reg <= 1'b0;
                  end
               end
               vps_pkg::DEC_DATA: begin
                  half_reg <= ~half_reg;
                  if (!half_reg) begin
                     h1_reg <= data_in;
                  end else begin
                     if (bit_bad) begin
                        err_reg <= 1'b1;
                     end
                     sh_reg <= byte_val[6:0];
                     bit_reg <= bit_reg + 3'h1;
                     if (byte_end) begin
                        byte_reg <= byte_reg + 4'h1;
                     end
                     if (last_byte) begin
                        got_ok_reg <= telegram_ok;
                        dec_reg <= vps_pkg::DEC_DONE;
                     end
                  end
               end
               vps_pkg::DEC_DONE: begin
                  dec_reg <= vps_pkg::DEC_DONE;
               end
            endcase
         end
      end
   end

   for (genvar i = 0; i < vps_pkg::NSLOT; i++) begin : g_slot
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            buf_reg[i] <= vps_pkg::BLANK_BYTE;
            tx_reg[i] <= vps_pkg::BLANK_BYTE;
         end else begin
            if (byte_end && slot_valid(byte_reg) && cur_slot == 3'(i)) begin
               buf_reg[i] <= byte_val;
            end
            if (commit) begin
               tx_reg[i] <= (cur_slot == 3'(i)) ? byte_val : buf_reg[i];
            end else if (bus.read_done) begin
               tx_reg[i] <= vps_pkg::BLANK_BYTE;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lp_reg <= 1'b0;
         ff_reg <= 1'b0;
         sda_out_reg <= 1'b0;
      end else begin
         lp_reg <= lp_next;
         ff_reg <= ff_next;
         sda_out_reg <= 1'b0;
      end
   end

   assign o_vps_line_present = lp_reg;
   assign o_first_field = ff_reg;
   assign o_sda_out = sda_out_reg;
   assign o_sda_oe = bus.sda_oe;
endmodule : vps_line16_decoder
`default_nettype wire

// ===== vps_line16_decoder_props.sv
// Purpose: Port checks for the label decoder
// Assumes: Pins sampled on i_mclk
// Notes: Helper flops follow the serial address phase and the time since test select
`timescale 1ns/1ps
`default_nettype none
module vps_line16_decoder_props #(
   parameter int unsigned LINE_GAP_CYC = 9600,
   parameter logic [13:0] START_PAT = 14'h3A65
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_composite_sync_b,
   input wire logic i_sliced_data,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_address_select,
   input wire logic i_test_select,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_vps_line_present,
   input wire logic o_first_field
);
   logic scl_reg, sda_reg;
   logic [3:0] cnt_reg, calm_reg;
   logic [7:0] addr_reg;
   wire logic scl_rise = i_scl && !scl_reg;
   wire logic go = i_scl && scl_reg && sda_reg && !i_sda;
   wire logic [7:0] own = {6'h08, i_address_select, 1'b1};
   wire logic calm = calm_reg == 4'hF;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         cnt_reg <= 4'hF;
         calm_reg <= 4'h0;
         addr_reg <= 8'h00;
      end else begin
         scl_reg <= i_scl;
         sda_reg <= i_sda;
         calm_reg <= i_test_select ? 4'h0 : calm_reg + {3'h0, !calm};
         if (go)
            cnt_reg <= 4'h0;
         else if (scl_rise && cnt_reg != 4'hF)
            cnt_reg <= cnt_reg + 4'h1;
         if (scl_rise)
            addr_reg <= {addr_reg[6:0], i_sda};
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   sequence s_stop;
      scl_reg && i_scl && !sda_reg && i_sda;
   endsequence
   sequence s_addr_end;
      scl_rise && cnt_reg == 4'h8;
   endsequence
   chk_pull_only: assert property (o_sda_out == 1'b0)
      else $error("data output not low");
   chk_oe_on_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
      else $error("data enable moved with clock high");
   chk_addr_quiet: assert property (cnt_reg != 4'h0 && cnt_reg < 4'h8 |-> !o_sda_oe)
      else $error("data driven during address");
   chk_addr_ack: assert property (
      s_addr_end |-> ##3 (o_sda_oe == ($past(addr_reg, 3) == own)))
      else $error("address acknowledge wrong");
   chk_stop_free: assert property (s_stop |-> ##[1:6] !o_sda_oe)
      else $error("data line held after stop");
   chk_present_sync: assert property (
      $changed(o_vps_line_present) && calm |-> !$past(i_composite_sync_b, 3))
      else $error("present flag moved away from sync");
   chk_field_sync: assert property (
      $changed(o_first_field) && calm |-> !$past(i_composite_sync_b, 3))
      else $error("field flag moved away from sync");
   chk_reset_quiet: assert property (disable iff (1'b0) !i_rst_b |->
      !o_sda_oe && !o_vps_line_present && !o_first_field)
      else $error("outputs active in reset");
endmodule : vps_line16_decoder_props
bind vps_line16_decoder vps_line16_decoder_props #(
   .LINE_GAP_CYC(LINE_GAP_CYC),
   .START_PAT(START_PAT)
) i_vps_line16_decoder_props (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_composite_sync_b(i_composite_sync_b),
   .i_sliced_data(i_sliced_data), .i_scl(i_scl), .i_sda(i_sda),
   .i_address_select(i_address_select), .i_test_select(i_test_select),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_vps_line_present(o_vps_line_present),
   .o_first_field(o_first_field)
);
`default_nettype wire

// ===== vps_i2c_master_model.sv
// Purpose: Serial bus master reading the decoder
// Assumes: Wire level made by the bench with a pull-up
// Notes: 48 ns bit period; data sampled late in clock high
`timescale 1ns/1ps
`default_nettype none
module vps_i2c_master_model (
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic xbit(input logic b, output logic r);
      #4 o_sda_low = !b;
      #20 o_scl = 1'b1;
      #23 r = i_sda_line;
      #1 o_scl = 1'b0;
   endtask : xbit
   task automatic read_xfer(input logic [7:0] addr, input int n, output logic ack,
      output logic [39:0] data);
      logic r;
      data = 40'h00_0000_0000;
      // Half-ns shift keeps every pin change off the rising clock edge
      #48.5 o_sda_low = 1'b1;
      #48 o_scl = 1'b0;
      for (int i = 7; i >= 0; i--)
         xbit(addr[i], r);
      xbit(1'b1, r);
      ack = !r;
      for (int k = 0; k < n && ack; k++) begin
         for (int i = 0; i < 8; i++) begin
            xbit(1'b1, r);
            data = {data[38:0], r};
         end
         xbit(k == n - 1, r);
      end
      #4 o_sda_low = 1'b1;
      #20 o_scl = 1'b1;
      #48 o_sda_low = 1'b0;
      #48;
   endtask : read_xfer
endmodule : vps_i2c_master_model
`default_nettype wire

// ===== tb_vps_line16_decoder.sv
// Purpose: Self-checking bench for the label decoder
// Assumes: Line gap shortened to 200 cycles
// Notes: Two fields differ only in short pulses before the broad pulse
`timescale 1ns/1ps
`default_nettype none
module tb_vps_line16_decoder;
   localparam int unsigned GAP = 200;
   localparam logic [39:0] DATA_EXP = 40'hB4C3_D2E1_5A;
   localparam logic [39:0] BLANK = 40'hFF_FFFF_FFFF;
   logic mclk = 1'b0;
   logic rst_b, sync_b, sdat, tsel, asel, ack, ff_a, ff_b;
   logic [39:0] rd;
   wire logic scl, m_low, sda_out, sda_oe, present, field;
   wire logic sda_line = !(m_low || sda_oe);
   int fail_count = 0;
   int n_tests = 0;
   always #2.5 mclk = !mclk;
   vps_line16_decoder #(.LINE_GAP_CYC(GAP)) i_vps_line16_decoder (
      .i_mclk(mclk), .i_rst_b(rst_b), .i_composite_sync_b(sync_b), .i_sliced_data(sdat),
      .i_scl(scl), .i_sda(sda_line), .i_address_select(asel), .i_test_select(tsel),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_vps_line_present(present),
      .o_first_field(field)
   );
   vps_i2c_master_model i_vps_i2c_master_model (
      .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(m_low)
   );
   task automatic stop_test;
      if (fail_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic cmp_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t flag %b want %b", $time, got, exp);
      end
   endtask : cmp_bit
   task automatic cmp_word(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t read %h want %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic pulse(input int low, input int len);
      sync_b = 1'b0;
      cyc(low);
      sync_b = 1'b1;
      cyc(len - low);
   endtask : pulse
   task automatic half(input logic v);
      sdat = v;
      cyc(40);
   endtask : half
   task automatic line16(input logic bad);
      logic [7:0] v;
      pulse(20, 40);
      for (int i = 13; i >= 0; i--)
         half(vps_pkg::START_PAT_DEF[i]);
      for (int n = 3; n <= 14; n++) begin
         v = {4'(n), ~4'(n)};
         for (int i = 7; i >= 0; i--) begin
            half(v[i]);
            half((bad && n == 7 && i == 0) ? v[i] : !v[i]);
         end
      end
      sdat = 1'b0;
      cyc(3000);
   endtask : line16
   task automatic field_run(input int eq, input logic bad, output logic ff);
      repeat (eq) pulse(8, 100);
      pulse(3100, 3300);
      repeat (14) pulse(20, 220);
      line16(bad);
      repeat (3) pulse(20, 220);
      ff = field;
   endtask : field_run
   task automatic rd5(input logic [7:0] a, input logic exp_ack, input logic [39:0] exp);
      i_vps_i2c_master_model.read_xfer(a, 5, ack, rd);
      cyc(1);
      cmp_bit(ack, exp_ack);
      if (exp_ack)
         cmp_word(rd, exp);
   endtask : rd5
   task automatic t_blank;
      rd5(8'h21, 1'b1, BLANK);
   endtask : t_blank
   task automatic t_refuse;
      rd5(8'h23, 1'b0, BLANK);
      rd5(8'h20, 1'b0, BLANK);
   endtask : t_refuse
   task automatic t_frames;
      repeat (3) pulse(20, 220);
      field_run(5, 1'b0, ff_a);
      field_run(4, 1'b0, ff_b);
      cmp_bit(ff_b, !ff_a);
      cmp_bit(present, 1'b1);
      rd5(8'h21, 1'b1, DATA_EXP);
      rd5(8'h21, 1'b1, BLANK);
   endtask : t_frames
   task automatic t_bad;
      field_run(ff_a ? 5 : 4, 1'b1, ff_b);
      cmp_bit(present, 1'b0);
      rd5(8'h21, 1'b1, BLANK);
   endtask : t_bad
   task automatic t_alt_addr;
      asel = 1'b1;
      cyc(4);
      rd5(8'h23, 1'b1, BLANK);
      rd5(8'h21, 1'b0, BLANK);
   endtask : t_alt_addr
   task automatic t_test_mode;
      logic p0, f0;
      tsel = 1'b1;
      sync_b = 1'b0;
      cyc(10);
      p0 = present;
      cmp_bit(field, 1'b1);
      sync_b = 1'b1;
      cyc(10);
      cmp_bit(present, !p0);
      asel = 1'b0;
      cyc(10);
      f0 = field;
      cmp_bit(present, 1'b0);
      cyc(40);
      cmp_bit(field, !f0);
      tsel = 1'b0;
      cyc(20);
   endtask : t_test_mode
   initial begin
      rst_b = 1'b0;
      sync_b = 1'b1;
      sdat = 1'b0;
      tsel = 1'b0;
      asel = 1'b0;
      cyc(8);
      rst_b = 1'b1;
      cyc(4);
      t_blank();
      t_refuse();
      t_frames();
      t_bad();
      t_alt_addr();
      t_test_mode();
      stop_test();
   end
   initial begin
      #450000;
      fail_count++;
      $display("MISMATCH %0t run limit reached", $time);
      stop_test();
   end
endmodule : tb_vps_line16_decoder
`default_nettype wire
